/* include/mac_host_params.svh */
// Constants for the host-side controller of the 100G MAC/PCS port.
// Functional notes
// [R1] Receive path forwards cut-through, no packet storage.
// [R2] Transmit path is one minimal-storage pipeline.
// [R3] Device drives per-cycle increment for each statistic.
// [R4] Transmit frame good only without any error.
// [R5] Receive frame good only without FCS/length/other errors.
// [R6] Received pause quanta reported on status outputs.
// [R7] Requested pause frames inserted into transmit stream.
// [R8] Optional RS-FEC in four-lane mode.
// [R9] Ten receive lane buses, 80 or 32 bits.
// [R10] Ten transmit lane buses, each own lane clock.
// [R11] Lanes 0-3 80 or 32 bits, others 32.
// [R12] Ten-lane mode uses low 32 bits of lanes 0-3.
// [R13] 80-bit word split into 16-bit and 64-bit groups.
// [R14] Lane data sampled on its recovered clock rise.
// [R15] Lane receive reset held while clock unstable.
// [R16] Transmit user clock at line rate over width.
// [R17] Receive user clock same frequency as transmit.
// [R18] Receive reset async high, at least 5 ns.
// [R19] Transmit reset async high, at least 5 ns.
// [R20] Device synchronises its resets internally.
// [R21] Stop transfers within four cycles of not-ready, resume within four.
// [R22] Increment outputs read zero without counted events.
`ifndef MAC_HOST_PARAMS_SVH
`define MAC_HOST_PARAMS_SVH

`define CLK_PERIOD_NS 5
`define RESET_MIN_NS 5
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINK_HALF_CYC 4
`define SETTLE_CYC 16
`define SETTLE_W 5
`define DIV_W 3
`define LANE_CNT 10
`define WIDE_LANES 4
`define NARROW_LANES 6
`define WORD_W 80
`define MAIN_W 64
`define UPPER_W 16
`define NARROW_W 32
`define SEG_W 128
`define MTY_W 4
`define INC_W 4
`define STAT_W 48

`endif

/* include/mac_host_pkg.sv */
// Types shared by the host-side controller files.
package mac_host_pkg;

    typedef enum logic [1:0] {
        SEQ_HOLD,
        SEQ_SETTLE,
        SEQ_RUN
    } seq_state_t;

endpackage

/* src/stat_accum.sv */
// Counter built from a per-cycle statistic increment.
`timescale 1ns/10ps
`default_nettype none
`include "mac_host_params.svh"

module stat_accum
    import mac_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic add_en,
    input wire logic [`INC_W-1:0] inc,
    output logic [`STAT_W-1:0] total
);

    logic [`STAT_W-1:0] total_reg;
    logic [`STAT_W-1:0] total_next;

    // The increment is zero in idle cycles, and it is added only in cycles with add_en high.
    always_comb begin
        total_next = total_reg;
        if (add_en) begin
            total_next = total_reg + {{(`STAT_W-`INC_W){1'b0}}, inc}; // R3 R22
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            total_reg <= 48'h0;
        end else begin
            total_reg <= total_next;
        end
    end

    assign total = total_reg;

endmodule
`default_nettype wire

/* src/mac_port_host.sv */
// Host-side controller: clocks, resets, lane words and flow-gated transmit feed.
`timescale 1ns/10ps
`default_nettype none
`include "mac_host_params.svh"

module mac_port_host
    import mac_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic four_lane_mode,
    input wire logic [`LANE_CNT-1:0] lane_lock,
    input wire logic transmit_accept_flag,
    input wire logic [`INC_W-1:0] stat_rx_inc,
    input wire logic [`INC_W-1:0] stat_tx_inc,
    input wire logic src_valid,
    input wire logic [`SEG_W-1:0] src_data,
    input wire logic src_sop,
    input wire logic src_eop,
    input wire logic src_err,
    input wire logic [`MTY_W-1:0] src_mty,
    output logic src_ready,
    output logic user_tx_clock,
    output logic user_rx_clock,
    output logic tx_reset,
    output logic rx_reset,
    output logic [`LANE_CNT-1:0] lane_recovered_clock,
    output logic [`LANE_CNT-1:0] lane_receive_reset,
    output logic [`WIDE_LANES-1:0][`UPPER_W-1:0] lane_rx_word_upper_group,
    output logic [`WIDE_LANES-1:0][`MAIN_W-1:0] lane_rx_word_main_group,
    output logic [`NARROW_LANES-1:0][`NARROW_W-1:0] lane_rx_word_narrow_group,
    output logic tx_ena,
    output logic [`SEG_W-1:0] tx_data,
    output logic tx_sop,
    output logic tx_eop,
    output logic tx_err,
    output logic [`MTY_W-1:0] tx_mty,
    output logic [`STAT_W-1:0] rx_stat_total,
    output logic [`STAT_W-1:0] tx_stat_total
);

    // Builds one lane word from the pattern; ten-lane mode keeps data in the low bits only.
    function automatic logic [`WORD_W-1:0] lane_word(input logic [3:0] lane,
                                                     input logic [`MAIN_W-1:0] pat,
                                                     input logic wide);
        logic [`WORD_W-1:0] w;
        w = {pat[`UPPER_W-1:0] ^ {12'h000, lane}, pat ^ {60'h0, lane}};
        if (!wide) begin
            w = {48'h0, w[`NARROW_W-1:0]}; // R12
        end
        return w;
    endfunction

    // Clock divider: one toggle register feeds every link-facing clock.
    logic [`DIV_W-1:0] div_cnt_reg, div_cnt_next;
    logic link_clk_reg, link_clk_next;
    logic fall_tick;

    always_comb begin
        div_cnt_next = div_cnt_reg + 3'h1;
        link_clk_next = link_clk_reg;
        fall_tick = 1'b0;
        if (div_cnt_reg == 3'(`LINK_HALF_CYC - 1)) begin
            div_cnt_next = 3'h0;
            link_clk_next = ~link_clk_reg;
            fall_tick = link_clk_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 3'h0;
            link_clk_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            link_clk_reg <= link_clk_next;
        end
    end

    // Pin synchronisers; the first stage feeds only the second.
    logic [`LANE_CNT-1:0] lock_s1_reg, lock_s2_reg;
    logic acc_s1_reg, acc_s2_reg;
    logic [`INC_W-1:0] rxi_s1_reg, rxi_s2_reg, txi_s1_reg, txi_s2_reg;

    // The increments are launched by the clock this block makes, so after two stages
    // they are settled well before the mid-cycle sample point.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_s1_reg <= 10'h000;
            lock_s2_reg <= 10'h000;
            acc_s1_reg <= 1'b0;
            acc_s2_reg <= 1'b0;
            rxi_s1_reg <= 4'h0;
            rxi_s2_reg <= 4'h0;
            txi_s1_reg <= 4'h0;
            txi_s2_reg <= 4'h0;
        end else begin
            lock_s1_reg <= lane_lock;
            lock_s2_reg <= lock_s1_reg;
            acc_s1_reg <= transmit_accept_flag;
            acc_s2_reg <= acc_s1_reg;
            rxi_s1_reg <= stat_rx_inc;
            rxi_s2_reg <= rxi_s1_reg;
            txi_s1_reg <= stat_tx_inc;
            txi_s2_reg <= txi_s1_reg;
        end
    end

    // Reset sequencer: resets stay high until the generated clocks have run a while.
    seq_state_t seq_reg, seq_next;
    logic [`SETTLE_W-1:0] settle_reg, settle_next;
    logic run;

    always_comb begin
        seq_next = seq_reg;
        settle_next = settle_reg;
        case (seq_reg)
            SEQ_HOLD: begin
                settle_next = '0;
                seq_next = SEQ_SETTLE;
            end
            SEQ_SETTLE: begin
                settle_next = settle_reg + 5'h01;
                if (settle_reg == 5'(`SETTLE_CYC + `RESET_MIN_CYC)) begin // R18 R19
                    seq_next = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                seq_next = SEQ_RUN;
            end
            default: begin
                seq_next = SEQ_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_reg <= SEQ_HOLD;
            settle_reg <= 5'h00;
        end else begin
            seq_reg <= seq_next;
            settle_reg <= settle_next;
        end
    end

    assign run = (seq_reg == SEQ_RUN);

    // Reset outputs and clocks, all registered.
    logic rst_out_reg, rst_out_next;
    logic [`LANE_CNT-1:0] lane_rst_reg, lane_rst_next;

    always_comb begin
        rst_out_next = ~run; // R18 R19
        lane_rst_next = ~lock_s2_reg | {`LANE_CNT{~run}}; // R15
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_out_reg <= 1'b1;
            lane_rst_reg <= 10'h3FF;
        end else begin
            rst_out_reg <= rst_out_next;
            lane_rst_reg <= lane_rst_next;
        end
    end

    assign tx_reset = rst_out_reg;
    assign rx_reset = rst_out_reg;
    assign user_tx_clock = link_clk_reg; // R16
    assign user_rx_clock = link_clk_reg; // R17
    assign lane_recovered_clock = {`LANE_CNT{link_clk_reg}};
    assign lane_receive_reset = lane_rst_reg;

    // Lane words change at the falling edge so they are stable at the rising edge.
    logic [`MAIN_W-1:0] pat_reg, pat_next;
    logic [`WIDE_LANES-1:0][`UPPER_W-1:0] up_reg, up_next;
    logic [`WIDE_LANES-1:0][`MAIN_W-1:0] main_reg, main_next;
    logic [`NARROW_LANES-1:0][`NARROW_W-1:0] nar_reg, nar_next;

    always_comb begin
        logic [`WORD_W-1:0] w;
        w = '0;
        pat_next = pat_reg;
        up_next = up_reg;
        main_next = main_reg;
        nar_next = nar_reg;
        if (fall_tick) begin // R14
            pat_next = pat_reg + 64'h0000_0000_0000_0001;
            for (int i = 0; i < `WIDE_LANES; i++) begin
                w = lane_word(4'(i), pat_reg, four_lane_mode); // R9 R11
                up_next[i] = w[`WORD_W-1:`MAIN_W]; // R13
                main_next[i] = w[`MAIN_W-1:0]; // R13
            end
            for (int i = 0; i < `NARROW_LANES; i++) begin
                w = lane_word(4'(i + `WIDE_LANES), pat_reg, 1'b0); // R11
                nar_next[i] = w[`NARROW_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pat_reg <= 64'h0;
            up_reg <= '0;
            main_reg <= '0;
            nar_reg <= '0;
        end else begin
            pat_reg <= pat_next;
            up_reg <= up_next;
            main_reg <= main_next;
            nar_reg <= nar_next;
        end
    end

    assign lane_rx_word_upper_group = up_reg;
    assign lane_rx_word_main_group = main_reg;
    assign lane_rx_word_narrow_group = nar_reg;

    // Transmit feed. The accept flag reaches src_ready three clocks after the pin moves,
    // which is well inside one user clock, so the stop and resume bounds hold easily.
    logic ready_reg, ready_next;
    logic ena_reg, ena_next;
    logic [`SEG_W-1:0] data_reg, data_next;
    logic sop_reg, sop_next, eop_reg, eop_next, err_reg, err_next;
    logic [`MTY_W-1:0] mty_reg, mty_next;
    logic take;

    always_comb begin
        ready_next = acc_s2_reg & run; // R21
        take = fall_tick & src_valid & ready_reg;
        ena_next = ena_reg;
        data_next = data_reg;
        sop_next = sop_reg;
        eop_next = eop_reg;
        err_next = err_reg;
        mty_next = mty_reg;
        if (fall_tick) begin
            ena_next = take; // R21
            if (take) begin
                data_next = src_data;
                sop_next = src_sop;
                eop_next = src_eop;
                err_next = src_err & src_eop;
                mty_next = src_eop ? src_mty : 4'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
            ena_reg <= 1'b0;
            data_reg <= 128'h0;
            sop_reg <= 1'b0;
            eop_reg <= 1'b0;
            err_reg <= 1'b0;
            mty_reg <= 4'h0;
        end else begin
            ready_reg <= ready_next;
            ena_reg <= ena_next;
            data_reg <= data_next;
            sop_reg <= sop_next;
            eop_reg <= eop_next;
            err_reg <= err_next;
            mty_reg <= mty_next;
        end
    end

    assign src_ready = ready_reg;
    assign tx_ena = ena_reg;
    assign tx_data = data_reg;
    assign tx_sop = sop_reg;
    assign tx_eop = eop_reg;
    assign tx_err = err_reg;
    assign tx_mty = mty_reg;

    // One sample per user cycle, taken mid-cycle from the synchronised increments.
    stat_accum rx_counter (
        .clk(clk),
        .rst_n(rst_n),
        .add_en(fall_tick & run),
        .inc(rxi_s2_reg), // R3 R22
        .total(rx_stat_total)
    );

    stat_accum tx_counter (
        .clk(clk),
        .rst_n(rst_n),
        .add_en(fall_tick & run),
        .inc(txi_s2_reg), // R3 R22
        .total(tx_stat_total)
    );

endmodule
`default_nettype wire

/* tb/mac_port_host_chk.sv */
// Port-level checker for the host controller.
`timescale 1ns/10ps
`default_nettype none
module mac_port_host_chk
    import mac_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] lane_lock,
    input wire logic transmit_accept_flag,
    input wire logic [3:0] stat_tx_inc,
    input wire logic src_ready,
    input wire logic user_tx_clock,
    input wire logic user_rx_clock,
    input wire logic tx_reset,
    input wire logic rx_reset,
    input wire logic [9:0] lane_receive_reset,
    input wire logic [9:0] lane_recovered_clock,
    input wire logic [3:0][63:0] lane_rx_word_main_group,
    input wire logic tx_ena,
    input wire logic [127:0] tx_data,
    input wire logic tx_eop,
    input wire logic tx_err,
    input wire logic [47:0] tx_stat_total
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence word_held;
        $stable(tx_data) [*7];
    endsequence
    sequence half_period;
        $stable(user_tx_clock) [*3] ##1 $changed(user_tx_clock);
    endsequence
    sequence lane_word_steady;
        $stable(lane_rx_word_main_group) [*3];
    endsequence
    AST_LANE_SETUP: assert property ($rose(lane_recovered_clock[0]) |-> lane_word_steady)
        else $error("lane word moved around recovered clock rise");
    AST_READY_DROP: assert property
        ($fell(transmit_accept_flag) |-> ##[1:4] !src_ready)
        else $error("ready held after accept fell");
    AST_READY_CAUSE: assert property
        (src_ready |-> !tx_reset && $past(transmit_accept_flag, 3))
        else $error("ready without cause");
    AST_RESET_PAIR: assert property (tx_reset == rx_reset)
        else $error("resets differ");
    AST_LANE_RESET: assert property
        ((~$past(lane_lock, 3) & ~lane_receive_reset) == 10'h000)
        else $error("lane reset low while unlocked");
    AST_TX_STANDS: assert property ($rose(tx_ena) |=> word_held)
        else $error("segment did not stand a user cycle");
    AST_ERR_EOP: assert property (tx_ena && tx_err |-> tx_eop)
        else $error("error flag off end word");
    AST_STAT_IDLE: assert property
        ((stat_tx_inc == 4'h0) [*4] |=> $stable(tx_stat_total))
        else $error("total moved without increment");
    AST_CLK_HALF: assert property ($changed(user_tx_clock) |=> half_period)
        else $error("user clock half period wrong");
    AST_CLK_SAME: assert property (user_rx_clock == user_tx_clock)
        else $error("user clocks differ");
endmodule
bind mac_port_host mac_port_host_chk i_chk (
    .clk(clk),
    .rst_n(rst_n),
    .lane_lock(lane_lock),
    .transmit_accept_flag(transmit_accept_flag),
    .stat_tx_inc(stat_tx_inc),
    .src_ready(src_ready),
    .user_tx_clock(user_tx_clock),
    .user_rx_clock(user_rx_clock),
    .tx_reset(tx_reset),
    .rx_reset(rx_reset),
    .lane_receive_reset(lane_receive_reset),
    .lane_recovered_clock(lane_recovered_clock),
    .lane_rx_word_main_group(lane_rx_word_main_group),
    .tx_ena(tx_ena),
    .tx_data(tx_data),
    .tx_eop(tx_eop),
    .tx_err(tx_err),
    .tx_stat_total(tx_stat_total)
);
`default_nettype wire

/* tb/dev_model.sv */
// Behavioural stand-in for the port device beyond the controller.
`timescale 1ns/10ps
`default_nettype none
module dev_model
    import mac_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic tx_reset,
    input wire logic user_tx_clock,
    input wire logic tx_ena,
    input wire logic tx_eop,
    input wire logic tx_err,
    output logic transmit_accept_flag,
    output logic [3:0] stat_rx_inc,
    output logic [3:0] stat_tx_inc
);
    logic ck_reg;
    logic [1:0] rst_sync_reg;
    // The device brings the async reset into its own clock domain, so the host needs no
    // synchroniser of its own; readiness stays low until that release has passed.
    always @(negedge clk or posedge tx_reset) begin
        if (tx_reset) begin
            rst_sync_reg <= 2'h3;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h0};
        end
    end
    // Frames are looped back, so an errored frame also counts as a bad received one.
    // Increments change only at a user clock rise and hold one user cycle.
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ck_reg <= 1'h0;
            stat_tx_inc <= 4'h0;
            stat_rx_inc <= 4'h0;
            transmit_accept_flag <= 1'h0;
        end else begin
            ck_reg <= user_tx_clock;
            transmit_accept_flag <= !stall && !rst_sync_reg[1];
            if (user_tx_clock && !ck_reg) begin
                stat_tx_inc <= {3'h0, tx_ena && tx_eop && !tx_err};
                stat_rx_inc <= {3'h0, tx_ena && tx_eop && tx_err};
            end
        end
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking testbench for the host controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import mac_host_pkg::*;
;
    logic clk, rst_n, four_lane_mode, stall, src_valid, src_sop, src_eop, src_err;
    logic src_ready, user_tx_clock, user_rx_clock, tx_reset, rx_reset, transmit_accept_flag;
    logic tx_ena, tx_sop, tx_eop, tx_err;
    logic [9:0] lane_lock, lane_receive_reset, lane_recovered_clock;
    logic [3:0] src_mty, tx_mty, stat_rx_inc, stat_tx_inc;
    logic [127:0] src_data, tx_data;
    logic [47:0] rx_stat_total, tx_stat_total;
    logic [3:0][15:0] lane_rx_word_upper_group;
    logic [3:0][63:0] lane_rx_word_main_group;
    logic [5:0][31:0] lane_rx_word_narrow_group;
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    mac_port_host i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .four_lane_mode(four_lane_mode),
        .lane_lock(lane_lock),
        .transmit_accept_flag(transmit_accept_flag),
        .stat_rx_inc(stat_rx_inc),
        .stat_tx_inc(stat_tx_inc),
        .src_valid(src_valid),
        .src_data(src_data),
        .src_sop(src_sop),
        .src_eop(src_eop),
        .src_err(src_err),
        .src_mty(src_mty),
        .src_ready(src_ready),
        .user_tx_clock(user_tx_clock),
        .user_rx_clock(user_rx_clock),
        .tx_reset(tx_reset),
        .rx_reset(rx_reset),
        .lane_recovered_clock(lane_recovered_clock),
        .lane_receive_reset(lane_receive_reset),
        .lane_rx_word_upper_group(lane_rx_word_upper_group),
        .lane_rx_word_main_group(lane_rx_word_main_group),
        .lane_rx_word_narrow_group(lane_rx_word_narrow_group),
        .tx_ena(tx_ena),
        .tx_data(tx_data),
        .tx_sop(tx_sop),
        .tx_eop(tx_eop),
        .tx_err(tx_err),
        .tx_mty(tx_mty),
        .rx_stat_total(rx_stat_total),
        .tx_stat_total(tx_stat_total)
    );
    dev_model i_dev (
        .clk(clk),
        .rst_n(rst_n),
        .stall(stall),
        .tx_reset(tx_reset),
        .user_tx_clock(user_tx_clock),
        .tx_ena(tx_ena),
        .tx_eop(tx_eop),
        .tx_err(tx_err),
        .transmit_accept_flag(transmit_accept_flag),
        .stat_rx_inc(stat_rx_inc),
        .stat_tx_inc(stat_tx_inc)
    );
    task check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task expire(input string what);
        n_fail++;
        $display("Error %s expected event seen timeout", what);
        report_and_stop();
    endtask
    task send(input logic [127:0] d, input logic s, e, r, input logic [3:0] m,
              input logic xr, input logic [3:0] xm);
        @(negedge clk);
        src_valid = 1'h1;
        src_data = d;
        src_sop = s;
        src_eop = e;
        src_err = r;
        src_mty = m;
        for (n = 0; n < 60 && !(tx_ena === 1'h1 && tx_data === d); n++) @(negedge clk);
        if (n == 60) expire("tx_take");
        check("tx_sop", tx_sop, s);
        check("tx_eop", tx_eop, e);
        check("tx_err", tx_err, xr);
        check("tx_mty", tx_mty, xm);
        src_valid = 1'h0;
    endtask
    task t_reset();
        check("tx_reset", tx_reset, 1'h1);
        check("rx_reset", rx_reset, 1'h1);
        check("src_ready", src_ready, 1'h0);
        @(negedge clk);
        rst_n = 1'h1;
        for (n = 0; n < 100 && src_ready !== 1'h1; n++) @(negedge clk);
        if (n == 100) expire("src_ready");
        check("tx_reset", tx_reset, 1'h0);
        check("rx_reset", rx_reset, 1'h0);
        check("lane_reset", lane_receive_reset, 10'h3FF);
        lane_lock = 10'h3F7;
        repeat (5) @(negedge clk);
        check("lane_reset", lane_receive_reset, 10'h008);
        lane_lock = 10'h3FF;
    endtask
    task t_lanes();
        repeat (10) @(negedge clk);
        check("upper", lane_rx_word_upper_group[0], lane_rx_word_main_group[0][15:0]);
        for (int k = 0; k < 6; k++)
            check("narrow", lane_rx_word_narrow_group[k] ^ 32'(k + 4),
                  lane_rx_word_main_group[0][31:0]);
        four_lane_mode = 1'h0;
        repeat (10) @(negedge clk);
        check("upper_off", lane_rx_word_upper_group, 64'h0);
        for (int k = 0; k < 4; k++)
            check("main_hi", lane_rx_word_main_group[k][63:32], 32'h0);
    endtask
    task t_frames();
        send(128'hA1, 1'h1, 1'h0, 1'h1, 4'h3, 1'h0, 4'h0);
        send(128'hA2, 1'h0, 1'h1, 1'h0, 4'h5, 1'h0, 4'h5);
        send(128'hA3, 1'h1, 1'h1, 1'h1, 4'h4, 1'h1, 4'h4);
    endtask
    task t_stall();
        @(negedge clk);
        stall = 1'h1;
        for (n = 0; n < 8 && src_ready !== 1'h0; n++) @(negedge clk);
        check("ready_drop", n <= 5, 1'h1);
        src_valid = 1'h1;
        src_data = 128'hB4;
        repeat (24) @(negedge clk);
        check("refused", tx_data === 128'hB4, 1'h0);
        check("idle", tx_ena, 1'h0);
        stall = 1'h0;
        send(128'hB4, 1'h1, 1'h1, 1'h0, 4'h0, 1'h0, 4'h0);
    endtask
    task t_stats();
        repeat (40) @(negedge clk);
        check("tx_total", tx_stat_total, 48'h2);
        check("rx_total", rx_stat_total, 48'h1);
    endtask
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'h0;
        four_lane_mode = 1'h1;
        lane_lock = 10'h000;
        stall = 1'h0;
        src_valid = 1'h0;
        src_data = 128'h0;
        src_sop = 1'h0;
        src_eop = 1'h0;
        src_err = 1'h0;
        src_mty = 4'h0;
        repeat (12) @(posedge clk);
        t_reset();
        t_lanes();
        t_frames();
        t_stall();
        t_stats();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        expire("run_time");
    end
endmodule
`default_nettype wire
